// ---- pkg/lbus_area_pkg.sv ----
// Purpose: Constants for the local bus area decoder and bus sizing engine
// Assumes: One 200 MHz clock, configuration held on plain ports
// Notes:   Rule summary below
// Contract
// - Endian strap caught at reset; low big-endian, high little-endian.
// - Widths 8, 16, 32 for memory; only 8 or 16 for card.
// - Narrow width splits access into cycles, address steps by width bytes.
// - 32-byte burst starts at requested data, wraps, holds bus throughout.
// - 8-byte and 16-byte requests become two or four 4-byte accesses.
// - Area chosen by address bits 28..26, codes 0..5 map areas 0..5.
// - Area 0 width comes from two width straps caught at reset.
// - Access to areas 0,1,2,4,5 asserts that area's active-low select.
// - SRAM reads use read strobe as OE; writes use four byte strobes.
// - Per-area software wait count from 0 to 25 cycles.
// - External wait stretches cycle; ignored when software wait is zero.
// - Per-area setup and hold of 0 to 7 cycles around strobes.
// - Cycle-start hold 0 or 1, effective only with setup of 1 or more.
// - Burst ROM on areas 0 and 1 takes a 0..7 burst pitch.
// - Burst ROM transfer cycle lasts 2 to 9 cycles by wait setting.
// - Areas 2,4,5 mapped away by map select get no chip select.
// - Area 3 is external memory only: no select or strobes.
// - Card mode on area 5 drives card enables; write strobes become card signals.
// - Card address-to-enable setup of 0 to 15 cycles; code drives enables with the address and delays only the strobe.
// - Card adds 0 to 50 extra wait cycles to the wait count.
package lbus_area_pkg;
	localparam int AREA_MSB       = 28;
	localparam int AREA_LSB       = 26;
	localparam logic [2:0] AREA3_CODE = 3'h3;
	localparam logic [2:0] AREA5_CODE = 3'h5;
	localparam logic [1:0] WIDTH_8  = 2'h1;
	localparam logic [1:0] WIDTH_16 = 2'h2;
	localparam logic [1:0] WIDTH_32 = 2'h3;
	localparam logic [4:0] MAX_SW_WAIT   = 5'h19;
	localparam logic [5:0] MAX_CARD_WAIT = 6'h32;
	localparam logic [5:0] BURST_BYTES   = 6'h20;
	localparam logic [5:0] LONG_BYTES    = 6'h04;
	localparam logic       RST_LITTLE    = 1'h0;
	localparam logic [1:0] RST_A0_WIDTH  = 2'h3;
	typedef enum logic [1:0] {
		IF_SRAM,
		IF_BROM,
		IF_MPX,
		IF_CARD
	} if_type_t;
	typedef enum logic [2:0] {
		SZ_BYTE,
		SZ_WORD,
		SZ_LONG,
		SZ_QUAD,
		SZ_OCTA,
		SZ_LINE
	} acc_size_t;
endpackage

// ---- logic/lbus_lane_steer.sv ----
// Purpose: Byte lane steering for one bus cycle
// Assumes: Bus cycle address low bits and width already known
// Notes:   Pure combinational; output register lives in the caller
`timescale 1ns/10ps
module lbus_lane_steer (
	// Cycle description
	input  wire logic [1:0]  i_addr_lo,
	input  wire logic [2:0]  i_nbytes,
	input  wire logic        i_little,
	input  wire logic [1:0]  i_width,
	// Data in, internal order
	input  wire logic [31:0] i_wdata,
	// Lane outputs
	output logic      [31:0] o_lane_data,
	output logic      [3:0]  o_lane_en
);
	logic [3:0] lane;
	logic [2:0] k;
	logic [7:0] b;
	always_comb begin
		o_lane_data = 32'h0;
		o_lane_en = 4'h0;
		lane = 4'h0;
		b = 8'h0;
		for (int i = 0; i < 4; i++) begin
			k = 3'(i);
			if (k < i_nbytes) begin
				// Big-endian puts first byte on the top lane of the device word
				b = i_little ? i_wdata[8*i +: 8] : i_wdata[8*(4-int'(i_nbytes))+8*(int'(i_nbytes)-1-i) +: 8];
				lane = 4'({2'h0, i_addr_lo} + {1'h0, k});
				if (i_width == lbus_area_pkg::WIDTH_8) begin
					lane = 4'h0;
				end else if (i_width == lbus_area_pkg::WIDTH_16) begin
					lane = {3'h0, lane[0]};
				end
				if (!i_little && i_width == lbus_area_pkg::WIDTH_16) begin
					lane = {3'h0, ~lane[0]};
				end else if (!i_little && i_width == lbus_area_pkg::WIDTH_32) begin
					lane = 4'(3 - int'(lane[1:0]));
				end
				o_lane_data[8*lane[1:0] +: 8] = b;
				o_lane_en[lane[1:0]] = 1'h1;
			end
		end
	end
endmodule

// ---- logic/lbus_area_ctrl.sv ----
// Purpose: Area decode, bus sizing and strobe timing for the local bus
// Assumes: Requester holds request until o_done; config stable while busy
// Notes:   Per-area settings arrive as packed plain ports, index = area code; map select bits 0..2 are areas 2,4,5
`timescale 1ns/10ps
module lbus_area_ctrl (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// Strap pins
	input  wire logic        i_endian_strap_pin,
	input  wire logic        i_area0_width_strap_hi,
	input  wire logic        i_area0_width_strap_lo,
	// Internal request
	input  wire logic        i_req,
	input  wire logic [28:0] i_addr,
	input  wire logic        i_write,
	input  wire logic [2:0]  i_size,
	input  wire logic [31:0] i_wdata,
	output logic             o_busy,
	output logic             o_done,
	output logic             o_beat,
	output logic [31:0]      o_rdata,
	// Per-area configuration, 6 areas
	input  wire logic [11:0] i_bus_width_field,
	input  wire logic [11:0] i_if_type,
	input  wire logic [29:0] i_software_wait_field,
	input  wire logic [17:0] i_setup_wait,
	input  wire logic [17:0] i_hold_wait,
	input  wire logic [5:0]  i_start_hold,
	input  wire logic [5:0]  i_burst_pitch_field,
	input  wire logic [2:0]  i_area_map_select_bit,
	// Card timing, area 5
	input  wire logic [3:0]  i_card_wait_field,
	input  wire logic [1:0]  i_card_extra_wait_field,
	input  wire logic [2:0]  i_card_address_setup_field,
	input  wire logic        i_card_address_hold_field,
	input  wire logic        i_card_use_card_wait,
	// External bus
	input  wire logic        i_ext_wait_b,
	input  wire logic [31:0] i_ext_data,
	output logic [25:0]      o_ext_addr,
	output logic [31:0]      o_ext_data,
	output logic             o_ext_data_oe,
	output logic [5:0]       o_area_chip_select_b,
	output logic             o_read_strobe_b,
	output logic [3:0]       o_byte_write_strobes_b,
	output logic             o_bus_cycle_start_b,
	output logic             o_card_enable_low_b,
	output logic             o_card_enable_high_b,
	// Status
	output logic             o_little,
	output logic [1:0]       o_area0_width
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD
	} state_t;

	function automatic logic [5:0] total_bytes(input logic [2:0] sz);
		case (sz)
			3'h0: total_bytes = 6'h01;
			3'h1: total_bytes = 6'h02;
			3'h2: total_bytes = 6'h04;
			3'h3: total_bytes = 6'h08;
			3'h4: total_bytes = 6'h10;
			default: total_bytes = lbus_area_pkg::BURST_BYTES;
		endcase
	endfunction

	function automatic logic [2:0] width_bytes(input logic [1:0] w);
		if (w == lbus_area_pkg::WIDTH_8) begin
			width_bytes = 3'h1;
		end else if (w == lbus_area_pkg::WIDTH_16) begin
			width_bytes = 3'h2;
		end else begin
			width_bytes = 3'h4;
		end
	endfunction

	state_t      state;
	logic        little;
	logic [1:0]  a0_width;
	logic [2:0]  area;
	logic [1:0]  width;
	logic [1:0]  iftype;
	logic        no_select;
	logic [4:0]  sw_wait;
	logic [6:0]  wait_total;
	logic [2:0]  setup;
	logic [2:0]  hold;
	logic [2:0]  pitch;
	logic        card;
	logic [28:0] cyc_addr;
	logic [5:0]  left;
	logic [5:0]  unit_left;
	logic [31:0] data_buf;
	logic [7:0]  cnt;
	logic        first_beat;
	logic [2:0]  step;
	logic [2:0]  nbytes;
	logic [31:0] lane_data;
	logic [3:0]  lane_en;
	logic        w_meta;
	logic        w_s2;
	logic        w_s3;
	logic        ext_wait;
	logic        wait_ok;

	// Strap capture on clocked reset only; no async load of pins
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			little <= i_endian_strap_pin;
			a0_width <= {i_area0_width_strap_hi, i_area0_width_strap_lo};
		end
	end
	assign o_little = little;
	assign o_area0_width = a0_width;

	// External wait input: three stages, change taken when last two agree
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			w_meta <= 1'h1;
			w_s2 <= 1'h1;
			w_s3 <= 1'h1;
			ext_wait <= 1'h0;
		end else begin
			w_meta <= i_ext_wait_b;
			w_s2 <= w_meta;
			w_s3 <= w_s2;
			if (w_s2 == w_s3) begin
				ext_wait <= ~w_s3;
			end
		end
	end

	// Area decode from latched cycle address
	always_comb begin
		area = cyc_addr[lbus_area_pkg::AREA_MSB:lbus_area_pkg::AREA_LSB];
		iftype = i_if_type[2*area +: 2];
		card = (area == lbus_area_pkg::AREA5_CODE) && (iftype == 2'(lbus_area_pkg::IF_CARD));
		if (area == 3'h0) begin
			width = a0_width;
			if (iftype == 2'(lbus_area_pkg::IF_CARD)) begin
				iftype = 2'(lbus_area_pkg::IF_SRAM);
			end
		end else begin
			width = i_bus_width_field[2*area +: 2];
		end
		if (width == 2'h0) begin
			width = lbus_area_pkg::WIDTH_32;
		end
		if (card && width == lbus_area_pkg::WIDTH_32) begin
			width = lbus_area_pkg::WIDTH_16;
		end
		no_select = (area == lbus_area_pkg::AREA3_CODE) || (area > 3'h5);
		if (area == 3'h2) begin
			no_select = no_select | i_area_map_select_bit[0];
		end else if (area == 3'h4) begin
			no_select = no_select | i_area_map_select_bit[1];
		end else if (area == 3'h5) begin
			no_select = no_select | i_area_map_select_bit[2];
		end
		sw_wait = card && i_card_use_card_wait ? {1'h0, i_card_wait_field}
			: i_software_wait_field[5*area +: 5];
		if (sw_wait > lbus_area_pkg::MAX_SW_WAIT) begin
			sw_wait = lbus_area_pkg::MAX_SW_WAIT;
		end
		wait_total = {2'h0, sw_wait};
		if (card) begin
			// Extra card wait code 0..3 gives 0, 10, 25, 50 cycles
			case (i_card_extra_wait_field)
				2'h0: wait_total = wait_total;
				2'h1: wait_total = 7'(wait_total + 7'h0a);
				2'h2: wait_total = 7'(wait_total + 7'h19);
				default: wait_total = 7'(wait_total + {1'h0, lbus_area_pkg::MAX_CARD_WAIT});
			endcase
		end
		setup = i_setup_wait[3*area +: 3];
		hold = i_hold_wait[3*area +: 3];
		pitch = (area < 3'h2) ? i_burst_pitch_field[3*area +: 3] : 3'h0;
		step = width_bytes(width);
		nbytes = (unit_left < {3'h0, step}) ? unit_left[2:0] : step;
	end

	lbus_lane_steer u_steer (
		.i_addr_lo   (cyc_addr[1:0]),
		.i_nbytes    (nbytes),
		.i_little    (little),
		.i_width     (width),
		.i_wdata     (data_buf),
		.o_lane_data (lane_data),
		.o_lane_en   (lane_en)
	);

	// External wait honoured only when software wait is nonzero
	assign wait_ok = (sw_wait == 5'h0) || !ext_wait;

	// Sequencer: setup, strobe with waits, hold; then next sized beat
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state <= ST_IDLE;
			cnt <= 8'h0;
			cyc_addr <= 29'h0;
			left <= 6'h0;
			unit_left <= 6'h0;
			first_beat <= 1'h0;
			o_done <= 1'h0;
			o_beat <= 1'h0;
		end else begin
			o_done <= 1'h0;
			o_beat <= 1'h0;
			case (state)
				ST_IDLE: begin
					if (i_req && !o_done) begin
						cyc_addr <= i_addr;
						left <= total_bytes(i_size);
						// Wide transfers go as 4-byte units
						unit_left <= (total_bytes(i_size) > lbus_area_pkg::LONG_BYTES)
							? lbus_area_pkg::LONG_BYTES : total_bytes(i_size);
						first_beat <= 1'h1;
						cnt <= 8'h0;
						state <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					cnt <= 8'(cnt + 8'h1);
					// Card setup uses address setup field plus hold bit as 4-bit count
					if ((card && cnt >= {4'h0, i_card_address_hold_field, i_card_address_setup_field})
						|| (!card && cnt >= {5'h0, setup})) begin
						cnt <= 8'h0;
						state <= ST_STROBE;
					end
				end
				ST_STROBE: begin
					cnt <= 8'(cnt + 8'h1);
					// Later burst ROM beats use the pitch: 2..9 cycles total
					if (((iftype == 2'(lbus_area_pkg::IF_BROM) && !first_beat)
						? (cnt >= {5'h0, pitch}) : (cnt >= {1'h0, wait_total}))
						&& wait_ok) begin
						o_beat <= 1'h1;
						cnt <= 8'h0;
						first_beat <= 1'h0;
						left <= 6'(left - {3'h0, nbytes});
						unit_left <= 6'(unit_left - {3'h0, nbytes});
						// Wraparound inside the 32-byte line
						if (left > lbus_area_pkg::LONG_BYTES) begin
							cyc_addr[4:0] <= 5'(cyc_addr[4:0] + {2'h0, nbytes});
						end else begin
							cyc_addr[1:0] <= 2'(cyc_addr[1:0] + nbytes[1:0]);
						end
						if (unit_left == {3'h0, nbytes}) begin
							unit_left <= lbus_area_pkg::LONG_BYTES;
						end
						state <= ST_HOLD;
					end
				end
				default: begin
					cnt <= 8'(cnt + 8'h1);
					if (cnt >= {5'h0, hold}) begin
						cnt <= 8'h0;
						if (left == 6'h0) begin
							o_done <= 1'h1;
							state <= ST_IDLE;
						end else if (iftype == 2'(lbus_area_pkg::IF_BROM)) begin
							state <= ST_STROBE;
						end else begin
							state <= ST_SETUP;
						end
					end
				end
			endcase
		end
	end

	// Read data capture per beat
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rdata <= 32'h0;
			data_buf <= 32'h0;
		end else if (state == ST_IDLE && i_req) begin
			data_buf <= i_wdata;
		end else if (o_beat && !o_read_strobe_b) begin
			// Strobe pin lags state, so data stands in the cycle after the beat
			o_rdata <= i_ext_data;
		end
	end

	// External pins, registered from current state, so they lag it by one cycle
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_ext_addr <= 26'h0;
			o_ext_data <= 32'h0;
			o_ext_data_oe <= 1'h0;
			o_area_chip_select_b <= 6'h3f;
			o_read_strobe_b <= 1'h1;
			o_byte_write_strobes_b <= 4'hf;
			o_bus_cycle_start_b <= 1'h1;
			o_card_enable_low_b <= 1'h1;
			o_card_enable_high_b <= 1'h1;
		end else begin
			o_ext_addr <= cyc_addr[25:0];
			o_ext_data <= lane_data;
			o_ext_data_oe <= (state != ST_IDLE) && i_write && !no_select;
			o_area_chip_select_b <= 6'h3f;
			o_read_strobe_b <= 1'h1;
			o_byte_write_strobes_b <= 4'hf;
			o_bus_cycle_start_b <= 1'h1;
			o_card_enable_low_b <= 1'h1;
			o_card_enable_high_b <= 1'h1;
			if (state != ST_IDLE && !no_select) begin
				if (!card) begin
					o_area_chip_select_b[area] <= 1'h0;
				end else begin
					o_area_chip_select_b[area] <= 1'h0;
					o_card_enable_low_b <= 1'h0;
					o_card_enable_high_b <= !(width == lbus_area_pkg::WIDTH_16 && nbytes > 3'h1);
				end
				// Start marker extends one cycle when start hold set and setup nonzero
				o_bus_cycle_start_b <= !((state == ST_SETUP && cnt == 8'h0)
					|| (state == ST_SETUP && cnt == 8'h1 && setup != 3'h0
					&& i_start_hold[area]));
				if (state == ST_STROBE) begin
					if (!i_write) begin
						o_read_strobe_b <= 1'h0;
					end else if (card) begin
						// Card: lane 1 is card write, driven low; lane 3 card I/O write stays high
						o_byte_write_strobes_b <= 4'b1101;
					end else begin
						o_byte_write_strobes_b <= ~lane_en;
					end
				end
			end
		end
	end

	assign o_busy = (state != ST_IDLE);
endmodule

// ---- dv/lbus_area_ctrl_asserts.sv ----
// Purpose: Port-level checks for the area controller
// Assumes: Requester holds address until o_done; config changed only while idle
// Notes:   Pins lag state by one cycle, so decode checks use the held address
`timescale 1ns/10ps
module lbus_area_ctrl_asserts (
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	// Straps and request
	input wire logic        i_endian_strap_pin,
	input wire logic        i_area0_width_strap_hi,
	input wire logic        i_area0_width_strap_lo,
	input wire logic        i_req,
	input wire logic [28:0] i_addr,
	input wire logic        i_write,
	input wire logic [2:0]  i_area_map_select_bit,
	// Outputs watched
	input wire logic        o_busy,
	input wire logic        o_done,
	input wire logic [5:0]  o_area_chip_select_b,
	input wire logic        o_read_strobe_b,
	input wire logic [3:0]  o_byte_write_strobes_b,
	input wire logic        o_card_enable_low_b,
	input wire logic        o_card_enable_high_b,
	input wire logic        o_little,
	input wire logic [1:0]  o_area0_width
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_endian_strap: assert property ($rose(i_rst_b) |-> o_little == $past(i_endian_strap_pin))
		else $error("endian mode differs from strap");
	a_width_strap: assert property ($rose(i_rst_b) && ($past(i_area0_width_strap_hi)
		|| $past(i_area0_width_strap_lo)) |-> o_area0_width == {$past(i_area0_width_strap_hi),
		$past(i_area0_width_strap_lo)})
		else $error("area 0 width differs from straps");
	a_straps_held: assert property ($stable(o_little) && $stable(o_area0_width))
		else $error("strap state changed outside reset");
	a_select_decode: assert property (o_area_chip_select_b != 6'h3f
		|-> ~o_area_chip_select_b == (6'h01 << i_addr[28:26]))
		else $error("wrong or several selects");
	a_map_away: assert property ((i_area_map_select_bit & $past(i_area_map_select_bit)
		& ~{o_area_chip_select_b[5], o_area_chip_select_b[4], o_area_chip_select_b[2]}) == 3'h0)
		else $error("select on mapped-away area");
	a_area3_quiet: assert property (o_busy && i_addr[28:26] == 3'h3 |-> o_area_chip_select_b == 6'h3f
		&& o_read_strobe_b && o_byte_write_strobes_b == 4'hf)
		else $error("pins active on area 3");
	a_read_select: assert property (!o_read_strobe_b && o_card_enable_low_b && o_card_enable_high_b
		|-> o_area_chip_select_b != 6'h3f && o_byte_write_strobes_b == 4'hf)
		else $error("read strobe without select or with write strobe");
	a_take_busy: assert property (!o_busy && i_req && !o_done |=> o_busy)
		else $error("request not taken");
	a_done_idle: assert property (o_done |-> !o_busy ##1 !o_done)
		else $error("done not a single pulse at idle");
	a_done_bound: assert property ($rose(o_busy) |-> ##[3:1000] o_done)
		else $error("transfer did not finish");

	cover property ($rose(o_done) && i_write);
	cover property (!o_card_enable_low_b);
	cover property ($fell(o_area_chip_select_b[0]));
endmodule

// ---- dv/ext_mem_model.sv ----
// Purpose: External memory seen behind the chip selects
// Assumes: Reads answer from the address; wait can stall each strobe
// Notes:   Released bus shows inverse of last word, never a stale copy
`timescale 1ns/10ps
module ext_mem_model (
	// Bus side
	input wire logic        i_clk,
	input wire logic [5:0]  i_cs_b,
	input wire logic        i_rd_b,
	input wire logic [25:0] i_addr,
	// Stall length from the bench
	input wire logic [3:0]  i_stall,
	output logic     [31:0] o_data,
	output logic            o_wait_b
);
	logic [31:0] last = 32'h0;
	logic [3:0]  cnt = 4'h0;
	logic        act;
	assign act = ~&i_cs_b & ~i_rd_b;
	always_ff @(posedge i_clk) begin
		if (act)
			last <= {~i_addr[15:0], i_addr[15:0]};
		cnt <= act ? ((cnt != 4'h0) ? cnt - 4'h1 : 4'h0) : i_stall;
	end
	assign o_data = act ? {~i_addr[15:0], i_addr[15:0]} : ~last;
	assign o_wait_b = !(act && cnt != 4'h0);
endmodule

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the area controller
// Assumes: Big-endian strap, area 0 strapped 8-bit
// Notes:   Table rows first, then timing, mapping and card cases
`timescale 1ns/10ps
module tb;
	typedef struct {logic [2:0] ar; logic [2:0] sz; logic wr; logic [7:0] off;} row_t;
	logic i_clk, i_rst_b, i_req, i_write, ewait_b, busy, done, beat, rd_b, ce_lo, ce_hi, little;
	logic bs_b, oe, rdl, st_hi, st_lo;
	logic [28:0] i_addr;
	logic [2:0] i_size, map, csetup;
	logic [31:0] ext_d, rdata, ext_do;
	logic [11:0] widths, itype;
	logic [29:0] sw;
	logic [17:0] su, ho;
	logic [1:0] cextra, a0w;
	logic [3:0] stall, we_b, mask;
	logic [5:0] cs_b, csl, sh, bp;
	logic [25:0] ext_a, a, la;
	logic [25:0] alog[$];
	int n_errors = 0, num_checks = 0, dur, ce_seen, b, w, d0, bsl;
	row_t rows[9] = '{'{3'h1,3'h2,1'b0,8'h00}, '{3'h0,3'h2,1'b1,8'h04}, '{3'h2,3'h0,1'b1,8'h01},
		'{3'h2,3'h1,1'b0,8'h02}, '{3'h4,3'h3,1'b0,8'h08}, '{3'h4,3'h4,1'b1,8'h10},
		'{3'h1,3'h5,1'b0,8'h18}, '{3'h0,3'h5,1'b1,8'h04}, '{3'h5,3'h0,1'b0,8'h03}};

	lbus_area_ctrl lbus_area_ctrl_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_endian_strap_pin(1'b0), .i_area0_width_strap_hi(st_hi), .i_area0_width_strap_lo(st_lo),
		.i_req(i_req), .i_addr(i_addr), .i_write(i_write), .i_size(i_size),
		.i_wdata(32'h11223344), .o_busy(busy), .o_done(done), .o_beat(beat), .o_rdata(rdata),
		.i_bus_width_field(widths), .i_if_type(itype), .i_software_wait_field(sw),
		.i_setup_wait(su), .i_hold_wait(ho), .i_start_hold(sh), .i_burst_pitch_field(bp),
		.i_area_map_select_bit(map), .i_card_wait_field(4'h0), .i_card_extra_wait_field(cextra),
		.i_card_address_setup_field(csetup), .i_card_address_hold_field(1'b0),
		.i_card_use_card_wait(1'b0), .i_ext_wait_b(ewait_b), .i_ext_data(ext_d),
		.o_ext_addr(ext_a), .o_ext_data(ext_do), .o_ext_data_oe(oe), .o_area_chip_select_b(cs_b),
		.o_read_strobe_b(rd_b), .o_byte_write_strobes_b(we_b), .o_bus_cycle_start_b(bs_b),
		.o_card_enable_low_b(ce_lo), .o_card_enable_high_b(ce_hi), .o_little(little),
		.o_area0_width(a0w));
	ext_mem_model ext_mem_model_i (.i_clk(i_clk), .i_cs_b(cs_b), .i_rd_b(rd_b), .i_addr(ext_a),
		.i_stall(stall), .o_data(ext_d), .o_wait_b(ewait_b));

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	function automatic logic [25:0] ea(input logic [25:0] x, input int bb, input int ww, input int k);
		return (bb < ww) ? x : ((x & ~(bb - 1)) | ((x + k * ww) & (bb - 1)));
	endfunction

	// Request held until done, pins sampled just after each edge
	task automatic run(input logic [2:0] ar, input logic [2:0] sz, input logic wr, input logic [25:0] x);
		@(negedge i_clk);
		i_addr = {ar, x};
		i_size = sz;
		i_write = wr;
		i_req = 1'b1;
		alog.delete();
		{mask, csl, rdl, ce_seen, dur, bsl} = '0;
		@(posedge i_clk);
		do begin
			@(posedge i_clk);
			#1;
			dur++;
			if (beat)
				alog.push_back(ext_a);
			mask |= ~we_b;
			csl |= ~cs_b;
			rdl |= ~rd_b;
			if (!ce_lo)
				ce_seen = 1;
			if (!bs_b)
				bsl++;
		end while (!done && dur < 3000);
		if (!done)
			n_errors++;
		@(negedge i_clk);
		i_req = 1'b0;
		repeat (2) @(negedge i_clk);
		$display("test area %0d size %0d done", ar, sz);
	endtask

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	initial begin
		#150000;
		n_errors++;
		test_done();
	end

	initial begin
		{i_rst_b, i_req, i_write, i_addr, i_size, map, csetup, cextra, stall, sw, su, ho} = '0;
		{sh, bp} = '0;
		{st_hi, st_lo} = 2'h1;
		itype = 12'h000;
		widths = 12'hbf8;
		repeat (10) @(negedge i_clk);
		i_rst_b = 1'b1;
		@(negedge i_clk);
		check("little", little, 0);
		check("a0_width", a0w, 1);
		check("idle_pins", {cs_b, rd_b, we_b, ce_lo, ce_hi, oe}, 14'h3ffe);
		foreach (rows[r]) begin
			b = 1 << rows[r].sz;
			w = (rows[r].ar == 3'h0) ? 1 : (rows[r].ar == 3'h1 || rows[r].ar == 3'h5) ? 2 : 4;
			a = 26'h100 + rows[r].off;
			run(rows[r].ar, rows[r].sz, rows[r].wr, a);
			check("beats", alog.size(), (b < w) ? 1 : b / w);
			check("select", csl, 6'h01 << rows[r].ar);
			foreach (alog[k])
				check("addr", alog[k], ea(a, b, w, k));
			la = ea(a, b, w, (b < w) ? 0 : b / w - 1);
			if (rows[r].wr)
				check("lanes", mask, (b >= w) ? (1 << w) - 1 : ((1 << b) - 1) << (w - b - a % w));
			else
				check("rdata", rdata, {~la[15:0], la[15:0]});
		end
		// Wait field above 25 shows the clipping
		sw[24:20] = 5'h1f;
		su[14:12] = 3'h2;
		ho[14:12] = 3'h3;
		run(3'h4, 3'h2, 1'b0, 26'h0);
		check("wait_dur", dur, (25 + 1) + (2 + 1) + (3 + 1));
		check("start_len", bsl, 1);
		// Short wait so the synchronised stall reaches the strobe end
		sw[24:20] = 5'h08;
		sh = 6'h10;
		stall = 4'h8;
		run(3'h4, 3'h2, 1'b0, 26'h0);
		check("ext_wait", dur > 9 + 3 + 4, 1);
		check("start_hold", bsl, 2);
		run(3'h2, 3'h2, 1'b0, 26'h0);
		check("wait_ignored", dur, 3);
		stall = 4'h0;
		map = 3'h1;
		run(3'h2, 3'h2, 1'b0, 26'h0);
		check("mapped_away", {csl, rdl}, 0);
		map = 3'h0;
		run(3'h3, 3'h2, 1'b1, 26'h0);
		check("area3_quiet", {csl, rdl, mask}, 0);
		itype = 12'h004;
		bp = 6'h18;
		run(3'h1, 3'h2, 1'b0, 26'h0);
		check("brom_beats", alog.size(), 2);
		check("brom_dur", dur, 3 + (3 + 2));
		itype = 12'hc00;
		run(3'h5, 3'h1, 1'b0, 26'h0);
		d0 = dur;
		check("card_enable", ce_seen, 1);
		cextra = 2'h1;
		run(3'h5, 3'h1, 1'b0, 26'h0);
		check("card_extra", dur, d0 + 10);
		csetup = 3'h3;
		run(3'h5, 3'h1, 1'b0, 26'h0);
		check("card_setup", dur, d0 + 13);
		test_done();
	end
endmodule

bind lbus_area_ctrl lbus_area_ctrl_asserts lbus_area_ctrl_asserts_i (.i_clk(i_clk),
	.i_rst_b(i_rst_b), .i_endian_strap_pin(i_endian_strap_pin),
	.i_area0_width_strap_hi(i_area0_width_strap_hi), .i_area0_width_strap_lo(i_area0_width_strap_lo),
	.i_req(i_req), .i_addr(i_addr), .i_write(i_write), .i_area_map_select_bit(i_area_map_select_bit),
	.o_busy(o_busy), .o_done(o_done), .o_area_chip_select_b(o_area_chip_select_b),
	.o_read_strobe_b(o_read_strobe_b), .o_byte_write_strobes_b(o_byte_write_strobes_b),
	.o_card_enable_low_b(o_card_enable_low_b), .o_card_enable_high_b(o_card_enable_high_b),
	.o_little(o_little), .o_area0_width(o_area0_width));
